// *** core/fcs_array_ctl.sv ***
// one flash array's instruction sequencer
// assumes host write/read strobes are one-cycle pulses on i_clock
`timescale 1ns/1ps
module fcs_array_ctl #(
  parameter int unsigned TIMEOUT_CYC = fcs_pkg::FCS_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_rst,
  // host bus and this array's select, which gates the strobes here
  input  wire logic                  i_sel,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  input  wire logic [11:0]           i_addr_low,
  input  wire logic [7:0]            i_data,
  // embedded algorithm
  input  wire logic                  i_done,
  output logic                       o_start,
  output logic [2:0]                 o_op,
  output logic                       o_busy,
  output logic                       o_read_array,
  output logic                       o_seq_read
);
  import fcs_pkg::*;

  typedef enum logic [3:0] {
    FCS_S_IDLE, FCS_S_UNL1, FCS_S_UNL2, FCS_S_PROG, FCS_S_ERA1, FCS_S_ERA2,
    FCS_S_ERA3, FCS_S_BUSY, FCS_S_BYPX
  } fcs_state_e;

  fcs_state_e              state_ff, nxt_state;
  logic                    bypass_ff, nxt_bypass;
  logic                    susp_ff, nxt_susp;
  logic                    start_ff, nxt_start;
  logic [2:0]              op_ff, nxt_op;
  logic [FCS_TMR_W-1:0]    tmr_ff;
  logic                    seq_rd_ff;
  logic                    busy_ff;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // low bits only
  wire is_u1   = (i_addr_low == FCS_UNLOCK1_ADDR) && (i_data == FCS_UNLOCK1_DATA);
  wire is_u2   = (i_addr_low == FCS_UNLOCK2_ADDR) && (i_data == FCS_UNLOCK2_DATA);
  wire wr_ev   = i_sel && i_wr;
  wire in_seq  = (state_ff != FCS_S_IDLE) && (state_ff != FCS_S_BUSY);
  wire tmo     = in_seq && (tmr_ff == FCS_TMR_W'(TIMEOUT_CYC - 1));

  always_comb begin
    nxt_state  = state_ff;
    nxt_bypass = bypass_ff;
    nxt_susp   = susp_ff;
    nxt_start  = 1'b0;
    nxt_op     = op_ff;
    unique case (state_ff)
      FCS_S_IDLE: begin
        if (wr_ev) begin
          if (is_u1) begin
            nxt_state = FCS_S_UNL1;
          end else if (bypass_ff && i_data == FCS_CMD_PROGRAM) begin
            nxt_state = FCS_S_PROG;
          end else if (bypass_ff && i_data == FCS_CMD_BYP_EXIT) begin
            nxt_state = FCS_S_BYPX;
          end else if (susp_ff && i_data == FCS_CMD_RESUME) begin
            nxt_susp  = 1'b0;
            nxt_op    = FCS_OP_RESUME;
            nxt_start = 1'b1;
            nxt_state = FCS_S_BUSY;
          end
        end
      end
      FCS_S_UNL1: begin
        if (wr_ev) begin
          nxt_state = is_u2 ? FCS_S_UNL2 : FCS_S_IDLE;
        end
      end
      FCS_S_UNL2: begin
        if (wr_ev) begin
          nxt_state = FCS_S_IDLE;
          if (i_addr_low == FCS_UNLOCK1_ADDR) begin
            if (i_data == FCS_CMD_PROGRAM) begin
              nxt_state = FCS_S_PROG;
            end else if (i_data == FCS_CMD_BYPASS) begin
              nxt_bypass = 1'b1;
            end else if (i_data == FCS_CMD_ERASE && !susp_ff) begin
              nxt_state = FCS_S_ERA1;
            end else if (i_data == FCS_CMD_RESET) begin
              nxt_bypass = 1'b0;
            end
          end
        end
      end
      FCS_S_PROG: begin
        if (wr_ev) begin
          nxt_op    = FCS_OP_PROGRAM;
          nxt_start = 1'b1;
          nxt_state = FCS_S_BUSY;
        end
      end
      FCS_S_ERA1: begin
        if (wr_ev) begin
          nxt_state = is_u1 ? FCS_S_ERA2 : FCS_S_IDLE;
        end
      end
      FCS_S_ERA2: begin
        nxt_state = (wr_ev && is_u2) ? FCS_S_ERA3 : (wr_ev ? FCS_S_IDLE : state_ff);
        if (wr_ev && is_u2) begin
          nxt_op = FCS_OP_NONE;
        end
      end
      FCS_S_ERA3: begin
        if (wr_ev) begin
          nxt_state = FCS_S_IDLE;
          if (i_data == FCS_CMD_CHIP) begin
            nxt_op    = FCS_OP_CHIP;
            nxt_start = 1'b1;
            nxt_state = FCS_S_BUSY;
          end else if (i_data == FCS_CMD_SECTOR) begin
            nxt_op    = FCS_OP_SECTOR;
            nxt_start = 1'b1;
            nxt_state = FCS_S_BUSY;
          end
        end
      end
      // bypass exit byte
      // own state, so a stray 10h or 30h after 90h cannot start an erase
      FCS_S_BYPX: begin
        if (wr_ev) begin
          nxt_state = FCS_S_IDLE;
          if (i_data == FCS_CMD_BYP_EX2) begin
            nxt_bypass = 1'b0;
          end
        end
      end
      FCS_S_BUSY: begin
        if (wr_ev && op_ff == FCS_OP_SECTOR && i_data == FCS_CMD_SUSPEND) begin
          nxt_susp  = 1'b1;
          nxt_op    = FCS_OP_SUSPEND;
          nxt_start = 1'b1;
          nxt_state = FCS_S_IDLE;
        end else if (i_done) begin
          nxt_state = FCS_S_IDLE;
          nxt_op    = FCS_OP_NONE;
        end
      end
    endcase
    // abandon on time-out or reset byte
    // a program data byte may legally be f0h, so it never aborts
    if (tmo || (in_seq && state_ff != FCS_S_PROG && wr_ev && i_data == FCS_CMD_RESET)) begin
      nxt_state = FCS_S_IDLE;
      nxt_start = 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_ff  <= FCS_S_IDLE;
      bypass_ff <= 1'b0;
      susp_ff   <= 1'b0;
      start_ff  <= 1'b0;
      op_ff     <= FCS_OP_NONE;
      busy_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      bypass_ff <= nxt_bypass;
      susp_ff   <= nxt_susp;
      start_ff  <= nxt_start;
      op_ff     <= nxt_op;
      busy_ff   <= (nxt_state == FCS_S_BUSY);
    end
  end

  // gap counter restarts on each accepted byte
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tmr_ff <= '0;
    end else if (!in_seq || wr_ev || (i_sel && i_rd)) begin
      tmr_ff <= '0;
    end else begin
      tmr_ff <= tmr_ff + FCS_TMR_W'(1);
    end
  end

  // reads while busy or mid-sequence are status reads
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      seq_rd_ff <= 1'b0;
    end else begin
      seq_rd_ff <= i_sel && i_rd && (state_ff != FCS_S_IDLE);
    end
  end

  assign o_start      = start_ff;
  assign o_op         = op_ff;
  assign o_busy       = busy_ff;
  assign o_read_array = (state_ff == FCS_S_IDLE);
  assign o_seq_read   = seq_rd_ff;

  AST_TMO_IDLE: assert property (@(posedge i_clock) disable iff (i_rst)
    tmo |=> state_ff == FCS_S_IDLE) else $error("timeout not abandoned");
  AST_START_BUSY: assert property (@(posedge i_clock) disable iff (i_rst)
    start_ff && op_ff != FCS_OP_SUSPEND |-> state_ff == FCS_S_BUSY)
    else $error("start without busy");
  AST_UNL1: assert property (@(posedge i_clock) disable iff (i_rst)
    state_ff == FCS_S_IDLE && wr_ev && is_u1 |=> state_ff == FCS_S_UNL1)
    else $error("unlock one missed");
  AST_UNL2_BAD: assert property (@(posedge i_clock) disable iff (i_rst)
    state_ff == FCS_S_UNL1 && wr_ev && !is_u2 |=> state_ff == FCS_S_IDLE)
    else $error("bad unlock two kept");
  AST_DONE_IDLE: assert property (@(posedge i_clock) disable iff (i_rst)
    state_ff == FCS_S_BUSY && i_done && !wr_ev |=> state_ff == FCS_S_IDLE)
    else $error("done not back to read");
  AST_NO_SEL: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_sel && !tmo && state_ff != FCS_S_BUSY |=> $stable(state_ff))
    else $error("unselected array moved");
  COV_PROG: cover property (@(posedge i_clock) start_ff && op_ff == FCS_OP_PROGRAM);
  COV_SECT: cover property (@(posedge i_clock) start_ff && op_ff == FCS_OP_SECTOR);
  COV_TMO:  cover property (@(posedge i_clock) tmo);

endmodule // fcs_array_ctl

// *** core/fcs_pkg.sv ***
// flash command sequencer package: command codes, unlock addresses, timing
// assumes a 100 MHz host bus clock and a byte-wide host data bus
package fcs_pkg;

  // ----------------------------------------------------------------
  // bus and select widths
  // ----------------------------------------------------------------
  localparam int unsigned FCS_ADDR_W    = 16;
  localparam int unsigned FCS_LOW_W     = 12;
  localparam int unsigned FCS_PAGE_W    = 8;
  localparam int unsigned FCS_MAIN_SECT = 8;
  localparam int unsigned FCS_BOOT_SECT = 4;
  localparam int unsigned FCS_PTERMS    = 3;

  // ----------------------------------------------------------------
  // unlock cycles and command bytes
  // ----------------------------------------------------------------
  localparam logic [11:0] FCS_UNLOCK1_ADDR = 12'h555;
  localparam logic [11:0] FCS_UNLOCK2_ADDR = 12'haaa;
  localparam logic [7:0]  FCS_UNLOCK1_DATA = 8'haa;
  localparam logic [7:0]  FCS_UNLOCK2_DATA = 8'h55;
  localparam logic [7:0]  FCS_CMD_PROGRAM  = 8'ha0;
  localparam logic [7:0]  FCS_CMD_BYPASS   = 8'h20;
  localparam logic [7:0]  FCS_CMD_BYP_EXIT = 8'h90;
  localparam logic [7:0]  FCS_CMD_BYP_EX2  = 8'h00;
  localparam logic [7:0]  FCS_CMD_ERASE    = 8'h80;
  localparam logic [7:0]  FCS_CMD_CHIP     = 8'h10;
  localparam logic [7:0]  FCS_CMD_SECTOR   = 8'h30;
  localparam logic [7:0]  FCS_CMD_SUSPEND  = 8'hb0;
  localparam logic [7:0]  FCS_CMD_RESUME   = 8'h30;
  localparam logic [7:0]  FCS_CMD_RESET    = 8'hf0;

  // ----------------------------------------------------------------
  // operation codes handed to the embedded algorithm
  // ----------------------------------------------------------------
  localparam logic [2:0] FCS_OP_NONE    = 3'h0;
  localparam logic [2:0] FCS_OP_PROGRAM = 3'h1;
  localparam logic [2:0] FCS_OP_CHIP    = 3'h2;
  localparam logic [2:0] FCS_OP_SECTOR  = 3'h3;
  localparam logic [2:0] FCS_OP_SUSPEND = 3'h4;
  localparam logic [2:0] FCS_OP_RESUME  = 3'h5;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned FCS_CLK_MHZ      = 100;
  localparam int unsigned FCS_TIMEOUT_US   = 80;
  // longest gap rounds down
  localparam int unsigned FCS_TIMEOUT_CYC  = FCS_TIMEOUT_US * FCS_CLK_MHZ;
  localparam int unsigned FCS_TMR_W        = 14;

endpackage

// *** core/fcs_top.sv ***
// flash command sequencer top: address decode and two array sequencers
// assumes host bus strobes come from logic on i_clock (no synchronisers)
`timescale 1ns/1ps
module fcs_top #(
  parameter int unsigned TIMEOUT_CYC = fcs_pkg::FCS_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                           i_clock,
  input  wire logic                           i_rst,
  // host bus
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  input  wire logic [fcs_pkg::FCS_ADDR_W-1:0] i_addr,
  input  wire logic [fcs_pkg::FCS_PAGE_W-1:0] i_page,
  input  wire logic [7:0]                     i_data,
  // embedded algorithm done, per array
  input  wire logic                           i_main_done,
  input  wire logic                           i_boot_done,
  // status
  output logic [fcs_pkg::FCS_MAIN_SECT-1:0]   o_main_array_sector_selects,
  output logic [fcs_pkg::FCS_BOOT_SECT-1:0]   o_boot_array_sector_selects,
  output logic                                o_main_start,
  output logic [2:0]                          o_main_op,
  output logic                                o_main_busy,
  output logic                                o_boot_start,
  output logic [2:0]                          o_boot_op,
  output logic                                o_boot_busy
);
  import fcs_pkg::*;

  // ----------------------------------------------------------------
  // address decode logic
  // ----------------------------------------------------------------
  // main selects, three terms, first used, other two spare
  logic [FCS_MAIN_SECT-1:0] main_sel;
  logic [FCS_BOOT_SECT-1:0] boot_sel;
  logic [FCS_MAIN_SECT-1:0] main_sel_ff;
  logic [FCS_BOOT_SECT-1:0] boot_sel_ff;
  wire  [3:0]               a_top = i_addr[15:12];
  genvar g;
  generate
    for (g = 0; g < FCS_MAIN_SECT; g++) begin : g_main
      wire t0 = (g < 2) ? (a_top[3:2] == 2'(g)) :
                ((i_page == FCS_PAGE_W'((g - 2) / 2)) && (a_top[3:2] == 2'(2 + g % 2)));
      wire t1 = 1'b0;
      wire t2 = 1'b0;
      assign main_sel[g] = t0 | t1 | t2;
    end
    for (g = 0; g < FCS_BOOT_SECT; g++) begin : g_boot
      wire t0 = (a_top[3:1] == 3'(4 + g));
      assign boot_sel[g] = t0 | 1'b0 | 1'b0;
    end
  endgenerate

  // boot array shadows main when both hit; one array per access
  wire boot_hit = |boot_sel;
  wire main_hit = (|main_sel) && !boot_hit;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      main_sel_ff <= '0;
      boot_sel_ff <= '0;
    end else begin
      main_sel_ff <= boot_hit ? '0 : main_sel;
      boot_sel_ff <= boot_sel;
    end
  end

  // ----------------------------------------------------------------
  // per-array sequencers
  // ----------------------------------------------------------------
  // each array sees only its own select
  fcs_array_ctl #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_main (
    .i_clock      (i_clock),
    .i_rst        (i_rst),
    .i_sel        (main_hit),
    .i_wr         (i_wr),
    .i_rd         (i_rd),
    .i_addr_low   (i_addr[FCS_LOW_W-1:0]),
    .i_data       (i_data),
    .i_done       (i_main_done),
    .o_start      (o_main_start),
    .o_op         (o_main_op),
    .o_busy       (o_main_busy),
    .o_read_array (),
    .o_seq_read   ()
  );

  fcs_array_ctl #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_boot (
    .i_clock      (i_clock),
    .i_rst        (i_rst),
    .i_sel        (boot_hit),
    .i_wr         (i_wr),
    .i_rd         (i_rd),
    .i_addr_low   (i_addr[FCS_LOW_W-1:0]),
    .i_data       (i_data),
    .i_done       (i_boot_done),
    .o_start      (o_boot_start),
    .o_op         (o_boot_op),
    .o_busy       (o_boot_busy),
    .o_read_array (),
    .o_seq_read   ()
  );

  assign o_main_array_sector_selects = main_sel_ff;
  assign o_boot_array_sector_selects = boot_sel_ff;

  AST_ONE_ARRAY: assert property (@(posedge i_clock) disable iff (i_rst)
    !(|main_sel_ff && |boot_sel_ff)) else $error("both arrays selected");
  AST_SEL_REG: assert property (@(posedge i_clock) disable iff (i_rst)
    boot_hit |=> |boot_sel_ff) else $error("boot select lost");
  COV_BOTH: cover property (@(posedge i_clock) o_main_busy && o_boot_busy);

endmodule // fcs_top

// *** verification/fcs_host_model.sv ***
// host bus master model: byte writes, reads and idle gaps towards fcs_top
// assumes the bench calls its tasks; all bus changes land on falling edges
`timescale 1ns/1ps
module fcs_host_model (
  // clock
  input  wire logic                           i_clock,
  // host bus towards the sequencer
  output logic                                o_wr,
  output logic                                o_rd,
  output logic [fcs_pkg::FCS_ADDR_W-1:0]      o_addr,
  output logic [fcs_pkg::FCS_PAGE_W-1:0]      o_page,
  output logic [7:0]                          o_data
);
  import fcs_pkg::*;

  initial begin
    o_wr   = 1'b0;
    o_rd   = 1'b0;
    o_addr = 16'h0;
    o_page = 8'h0;
    o_data = 8'h0;
  end

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clock);
    o_wr   = 1'b1;
    o_addr = a;
    o_data = d;
    @(negedge i_clock);
    o_wr   = 1'b0;
    // released data bus shows the inverse, not a stale copy
    o_data = ~d;
  endtask

  task automatic rd(input logic [15:0] a);
    @(negedge i_clock);
    o_rd   = 1'b1;
    o_addr = a;
    @(negedge i_clock);
    o_rd   = 1'b0;
  endtask

  // page stays put until changed here
  task automatic set_bus(input logic [15:0] a, input logic [7:0] p);
    @(negedge i_clock);
    o_addr = a;
    o_page = p;
    @(negedge i_clock);
  endtask

  task automatic gap(input int n);
    repeat (n) @(negedge i_clock);
  endtask
endmodule // fcs_host_model

// *** verification/tb_top.sv ***
// self-checking bench for fcs_top with a host model and algorithm responder
// assumes a shortened time-out parameter of 50 cycles
`timescale 1ns/1ps
module tb_top;
  import fcs_pkg::*;
  localparam int unsigned TMO = 50;
  logic        i_clock = 1'b0;
  logic        i_rst   = 1'b1;
  logic        i_wr, i_rd;
  logic [15:0] i_addr;
  logic [7:0]  i_page, i_data;
  logic [1:0]  done_ff = 2'h0;
  logic [1:0]  hold    = 2'h0;
  logic [7:0]  msel;
  logic [3:0]  bsel;
  wire  [1:0]  st, busy;
  logic [2:0]  mop, bop;
  int          dly[2]  = '{0, 0};
  int          cnt[2]  = '{0, 0};
  int          n_errors = 0;
  int          n_compared = 0;

  always #5 i_clock = ~i_clock;

  fcs_host_model i_fcs_host_model (.i_clock(i_clock), .o_wr(i_wr), .o_rd(i_rd),
    .o_addr(i_addr), .o_page(i_page), .o_data(i_data));

  fcs_top #(.TIMEOUT_CYC(TMO)) i_fcs_top (.i_clock(i_clock), .i_rst(i_rst), .i_wr(i_wr),
    .i_rd(i_rd), .i_addr(i_addr), .i_page(i_page), .i_data(i_data),
    .i_main_done(done_ff[0]), .i_boot_done(done_ff[1]),
    .o_main_array_sector_selects(msel), .o_boot_array_sector_selects(bsel),
    .o_main_start(st[0]), .o_main_op(mop), .o_main_busy(busy[0]),
    .o_boot_start(st[1]), .o_boot_op(bop), .o_boot_busy(busy[1]));

  // ------------------------------------------------------------
  // start counter and embedded algorithm responder
  // ------------------------------------------------------------
  always @(posedge i_clock) begin
    for (int a = 0; a < 2; a++) begin
      if (st[a] === 1'b1) cnt[a] <= cnt[a] + 1;
    end
  end

  // hold keeps an erase running so that it can be suspended
  always @(negedge i_clock) begin
    for (int a = 0; a < 2; a++) begin
      done_ff[a] <= 1'b0;
      if (busy[a] === 1'b1 && !hold[a] && !done_ff[a]) begin
        if (dly[a] == 6) begin
          done_ff[a] <= 1'b1;
          dly[a] <= 0;
        end else dly[a] <= dly[a] + 1;
      end else dly[a] <= 0;
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [7:0] exp_main(input logic [15:0] ad, input logic [7:0] pg);
    logic [7:0] s;
    s = 8'h0;
    s[0] = ad[15:14] == 2'b00;
    s[1] = ad[15:14] == 2'b01;
    for (int p = 0; p < 3; p++) begin
      s[2+2*p] = pg == 8'(p) && ad[15:14] == 2'b10;
      s[3+2*p] = pg == 8'(p) && ad[15:14] == 2'b11;
    end
    // boot array owns the upper half, so main selects stay low there
    return ad[15] ? 8'h0 : s;
  endfunction

  // random bits 15:12 inside the chosen array's range
  task automatic w(input int a, input logic [11:0] lo, input logic [7:0] d);
    logic [3:0] hi;
    hi = (a == 1) ? 4'h8 | 4'($urandom % 8) : 4'($urandom % 8);
    i_fcs_host_model.wr({hi, lo}, d);
  endtask

  task automatic unlock(input int a);
    w(a, 12'h555, 8'haa);
    w(a, 12'haaa, 8'h55);
  endtask

  task automatic expect_op(input int a, input int n, input logic [2:0] op);
    int k;
    if (op == FCS_OP_NONE) repeat (8) @(negedge i_clock);
    for (k = 0; k < 8 && cnt[a] != n; k++) @(negedge i_clock);
    cmp(8'(cnt[a]), 8'(n), "start count");
    if (op != FCS_OP_NONE) cmp({5'h0, a == 1 ? bop : mop}, {5'h0, op}, "op");
    if (cnt[a] != n) tally_and_finish();
  endtask

  task automatic wait_idle(input int a);
    int k;
    for (k = 0; k < 300 && busy[a] !== 1'b0; k++) @(negedge i_clock);
    if (k == 300) begin
      n_errors++;
      $display("MISMATCH t=%0t busy never dropped", $time);
      tally_and_finish();
    end
  endtask

  task automatic bad(input int a, input logic [11:0] l1, input logic [7:0] d1,
                     input logic [7:0] d2, input logic [7:0] d3, input int g);
    int c;
    c = cnt[a];
    w(a, l1, d1);
    w(a, 12'haaa, d2);
    w(a, 12'h555, d3);
    i_fcs_host_model.gap(g);
    w(a, 12'h123, 8'h5a);
    expect_op(a, c, FCS_OP_NONE);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [15:0] ad;
    logic [7:0]  pg;
    int          a, c, o;
    void'($urandom(39454));
    repeat (20) @(posedge i_clock);
    @(negedge i_clock);
    i_rst = 1'b0;
    cmp({msel}, 8'h0, "reset main selects");
    cmp({st, busy, bsel}, 8'h0, "reset flags");
    cmp({2'h0, mop, bop}, 8'h0, "reset ops");
    for (int i = 0; i < 12; i++) begin
      ad = 16'($urandom);
      pg = 8'($urandom % 4);
      i_fcs_host_model.set_bus(ad, pg);
      cmp(msel, exp_main(ad, pg), "main selects");
      cmp({4'h0, bsel}, {4'h0, ad[15] ? 4'h1 << ad[14:13] : 4'h0}, "boot selects");
    end
    for (int i = 0; i < 16; i++) begin
      a = $urandom % 2;
      c = cnt[a];
      o = cnt[1-a];
      unlock(a);
      w(a, 12'h555, FCS_CMD_PROGRAM);
      w(a, 12'($urandom), 8'($urandom));
      expect_op(a, c + 1, FCS_OP_PROGRAM);
      cmp(8'(cnt[1-a]), 8'(o), "other array idle");
      i_fcs_host_model.rd({a == 1 ? 4'h9 : 4'h1, 12'h0});
      cmp({7'h0, busy[a]}, 8'h1, "busy across read");
      wait_idle(a);
      @(negedge i_clock);
      cmp({7'h0, busy[a]}, 8'h0, "busy after done");
    end
    for (a = 0; a < 2; a++) begin
      bad(a, 12'h555, 8'haa, 8'h54, FCS_CMD_PROGRAM, 0);
      bad(a, 12'h556, 8'haa, 8'h55, FCS_CMD_PROGRAM, 0);
      bad(a, 12'h555, 8'haa, 8'h55, FCS_CMD_RESET, 0);
      bad(a, 12'h555, 8'haa, 8'h55, FCS_CMD_PROGRAM, TMO + 10);
      c = cnt[a];
      w(a, 12'h555, 8'haa);
      i_fcs_host_model.gap(TMO - 5);
      w(a, 12'haaa, 8'h55);
      i_fcs_host_model.gap(TMO - 5);
      w(a, 12'h555, FCS_CMD_PROGRAM);
      i_fcs_host_model.gap(TMO - 5);
      w(a, 12'h042, 8'h3c);
      expect_op(a, c + 1, FCS_OP_PROGRAM);
      wait_idle(a);
      for (int e = 0; e < 2; e++) begin
        unlock(a);
        w(a, 12'h555, FCS_CMD_ERASE);
        unlock(a);
        w(a, 12'h555, e == 0 ? FCS_CMD_CHIP : FCS_CMD_SECTOR);
        expect_op(a, c + 2 + e, e == 0 ? FCS_OP_CHIP : FCS_OP_SECTOR);
        wait_idle(a);
      end
      c = cnt[a];
      unlock(a);
      w(a, 12'h555, FCS_CMD_BYPASS);
      for (int k = 1; k < 3; k++) begin
        w(a, 12'h555, FCS_CMD_PROGRAM);
        w(a, 12'($urandom), 8'($urandom));
        expect_op(a, c + k, FCS_OP_PROGRAM);
        wait_idle(a);
      end
      w(a, 12'h555, FCS_CMD_BYP_EXIT);
      w(a, 12'h555, FCS_CMD_BYP_EX2);
      w(a, 12'h555, FCS_CMD_PROGRAM);
      w(a, 12'h0aa, 8'h11);
      expect_op(a, c + 2, FCS_OP_NONE);
      hold[a] = 1'b1;
      unlock(a);
      w(a, 12'h555, FCS_CMD_ERASE);
      unlock(a);
      w(a, 12'h555, FCS_CMD_SECTOR);
      expect_op(a, c + 3, FCS_OP_SECTOR);
      w(a, 12'h555, FCS_CMD_SUSPEND);
      expect_op(a, c + 4, FCS_OP_SUSPEND);
      w(a, 12'h555, FCS_CMD_RESUME);
      expect_op(a, c + 5, FCS_OP_RESUME);
      hold[a] = 1'b0;
      wait_idle(a);
    end
    tally_and_finish();
  end
endmodule // tb_top
